// *** verilog/pimsc_pkg.sv ***
// shared constants and types of the load switch mask, status and control bank
package pimsc_pkg;

	// register offsets (i2c sub-addresses)
	localparam logic [7:0] REG_MASK_OFS = 8'h04;
	localparam logic [7:0] REG_STATUS_OFS = 8'h05;
	localparam logic [7:0] REG_CTRL_OFS = 8'h06;

	// load switch mask register fields
	localparam int MASK_WIDTH = 6;
	localparam int MASK_FAULT_LSB = 3;
	localparam int MASK_ILIM_LSB = 0;
	localparam logic [5:0] MASK_RESET = 6'h00;

	// status register fields
	localparam int STAT_SEAL_BIT = 7;
	localparam int STAT_NVM_BIT = 6;
	localparam int STAT_SUPPLY_BIT = 5;
	localparam int STAT_BUTTON_BIT = 4;
	localparam int STAT_STATE_LSB = 2;
	localparam int STAT_CC_LSB = 0;

	// control register fields
	localparam int CTRL_PF_BIT = 1;
	localparam int CTRL_CC_BIT = 0;
	localparam logic CTRL_PF_RESET = 1'b0;
	localparam logic CTRL_CC_RESET = 1'b0;

	// coin cell level codes
	localparam logic [1:0] CC_LEVEL_RESET = 2'h0;

	// power state codes as reported in the status register
	localparam logic [1:0] PSTATE_TRANSIT = 2'h0;
	localparam logic [1:0] PSTATE_AWAIT_EN = 2'h1;
	localparam logic [1:0] PSTATE_ACTIVE = 2'h2;
	localparam logic [1:0] PSTATE_SUSPEND = 2'h3;

	// seven-bit i2c device address
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h24;

	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int ACQ_TIME_NS = 2000;
	localparam int ACQ_CYCLES_DEFAULT =
		(ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// i2c slave states
	typedef enum logic [2:0] {
		I2C_IDLE,
		I2C_ADDR,
		I2C_AACK,
		I2C_REG,
		I2C_WACK,
		I2C_WDATA,
		I2C_RDATA,
		I2C_RACK
	} pimsc_i2c_e;

endpackage : pimsc_pkg

// *** verilog/pimsc_irq_gate.sv ***
// mask and combine of the load switch interrupt events onto the irq pin
`timescale 1ns/10ps
module pimsc_irq_gate #(
	parameter int N = 6
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic [N-1:0] event_i,
	input wire logic [N-1:0] mask_i,
	output logic irq_n_o
);

	typedef struct packed {
		logic irq_n;
	} pimsc_gate_s;

	pimsc_gate_s gate_q;
	pimsc_gate_s gate_d;

	// mask only gates propagation, events are never altered here
	always_comb begin
		gate_d = gate_q;
		gate_d.irq_n = ~|(event_i & ~mask_i);
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			gate_q <= '{irq_n: 1'b1};
		end else if (ce_i) begin
			gate_q <= gate_d;
		end
	end

	assign irq_n_o = gate_q.irq_n;

endmodule : pimsc_irq_gate

// *** verilog/pimsc_coin_acq.sv ***
// coin cell voltage acquisition sequencer
`timescale 1ns/10ps
module pimsc_coin_acq #(
	parameter int CYCLES = 100
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic go_i,
	input wire logic [1:0] compare_i,
	output logic busy_o,
	output logic done_o,
	output logic [1:0] level_o
);
	import pimsc_pkg::*;

	localparam int CW = $clog2(CYCLES + 1);

	typedef struct packed {
		logic busy;
		logic done;
		logic [CW-1:0] cnt;
		logic [1:0] level;
	} pimsc_acq_s;

	pimsc_acq_s acq_q;
	pimsc_acq_s acq_d;

	always_comb begin
		acq_d = acq_q;
		acq_d.done = 1'b0;
		if (acq_q.busy) begin
			if (acq_q.cnt <= CW'(1)) begin
				// result latched at the end of the measuring window
				acq_d.busy = 1'b0;
				acq_d.done = 1'b1;
				acq_d.level = compare_i;
			end else begin
				acq_d.cnt = acq_q.cnt - CW'(1);
			end
		end else if (go_i && !acq_q.done) begin
			acq_d.busy = 1'b1;
			acq_d.cnt = CW'(CYCLES);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			acq_q <= '{busy: 1'b0, done: 1'b0, cnt: '0,
				level: CC_LEVEL_RESET};
		end else if (ce_i) begin
			acq_q <= acq_d;
		end
	end

	assign busy_o = acq_q.busy;
	assign done_o = acq_q.done;
	assign level_o = acq_q.level;

endmodule : pimsc_coin_acq

// *** verilog/pimsc_top.sv ***
// i2c reachable load switch mask, status and control register bank
//
// Function
// - mask bits 5..3 hold the fault interrupt masks of switches 3..1, reset 0.
// - mask bits 2..0 hold the current-limit masks of switches 3..1, reset 0.
// - an event with mask 0 pulls the irq pin low, with mask 1 it is ignored.
// - masking never changes monitoring or detection, only propagation.
// - status bit 7 is 0 while the freshness seal is intact, 1 once broken.
// - status bit 6 is 1 once non-volatile defaults have been changed.
// - status bit 5 reads 1 while the supply-detect pin is low, else 0.
// - status bit 4 reads 1 while the push-button pin is low, else 0.
// - status bits 3-2 give the power state: transit, await, active, suspend.
// - status bits 1-0 give the coin cell level from low to ideal.
// - with control bit 1 set a low power-fail output shuts all rails off.
// - writing 1 to control bit 0 starts an acquisition and self-clears.
// - a current-limit event is present only while that switch limits.
`timescale 1ns/10ps
module pimsc_top #(
	parameter logic [6:0] DEV_ADDR = pimsc_pkg::DEV_ADDR_DEFAULT,
	parameter int ACQ_CYCLES = pimsc_pkg::ACQ_CYCLES_DEFAULT
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic [2:0] sw_fault_i,
	input wire logic [2:0] sw_ilimit_i,
	input wire logic seal_broken_i,
	input wire logic nvm_modified_i,
	input wire logic external_supply_detect_n_i,
	input wire logic push_button_input_n_i,
	input wire logic [1:0] power_state_i,
	input wire logic [1:0] coin_cell_compare_i,
	input wire logic powerfail_out_n_i,
	output logic irq_out_n_o,
	output logic powerfail_shutdown_o,
	output logic coin_cell_measure_o
);
	import pimsc_pkg::*;

	typedef struct packed {
		pimsc_i2c_e st;
		logic scl;
		logic sda;
		logic [3:0] bits;
		logic [7:0] sh;
		logic rw;
		logic nack;
		logic [7:0] ptr;
		logic oe;
		logic [MASK_WIDTH-1:0] mask;
		logic pf_en;
		logic cc_go;
		logic pf_off;
	} pimsc_state_s;

	pimsc_state_s state_q;
	pimsc_state_s state_d;

	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic [7:0] status_w;
	logic [7:0] rd_w;
	logic [5:0] event_w;
	logic cc_done_w;
	logic cc_busy_w;
	logic [1:0] cc_level_w;

	// read value of the register at a sub-address; unmapped reads 00h
	function automatic logic [7:0] rd_byte(
		input logic [7:0] ptr,
		input logic [7:0] stat,
		input logic [MASK_WIDTH-1:0] mask,
		input logic pf,
		input logic go
	);
		logic [7:0] r;
		r = 8'h00;
		case (ptr)
			REG_MASK_OFS: begin
				r[MASK_WIDTH-1:0] = mask;
			end
			REG_STATUS_OFS: begin
				r = stat;
			end
			REG_CTRL_OFS: begin
				r[CTRL_PF_BIT] = pf;
				r[CTRL_CC_BIT] = go;
			end
			default: begin
				r = 8'h00;
			end
		endcase
		return r;
	endfunction : rd_byte

	// sub-address after a byte; wraps only from FFh to 00h
	function automatic logic [7:0] next_ptr(input logic [7:0] p);
		return p + 8'h01;
	endfunction : next_ptr

	// bit counter step within a byte
	function automatic logic [3:0] next_bit(input logic [3:0] b);
		return b + 4'h1;
	endfunction : next_bit

	// next state when a read byte is due, after the address ack or a host ack
	function automatic pimsc_state_s load_read(input pimsc_state_s s,
		input logic [7:0] b);
		pimsc_state_s n;
		n = s;
		n.bits = 4'h0;
		n.sh = b;
		n.oe = ~b[7];
		n.ptr = next_ptr(s.ptr);
		n.st = I2C_RDATA;
		return n;
	endfunction : load_read

	// status is sampled live at the moment a read byte is loaded
	always_comb begin
		status_w = 8'h00;
		status_w[STAT_SEAL_BIT] = seal_broken_i;
		status_w[STAT_NVM_BIT] = nvm_modified_i;
		status_w[STAT_SUPPLY_BIT] = ~external_supply_detect_n_i;
		status_w[STAT_BUTTON_BIT] = ~push_button_input_n_i;
		status_w[STAT_STATE_LSB +: 2] = power_state_i;
		status_w[STAT_CC_LSB +: 2] = cc_level_w;
	end

	assign rd_w = rd_byte(state_q.ptr, status_w, state_q.mask,
		state_q.pf_en, state_q.cc_go);

	// bus conditions seen against the previous sample of the pins
	assign rise = ~state_q.scl & scl_i;
	assign fall = state_q.scl & ~scl_i;
	assign start = state_q.scl & scl_i & state_q.sda & ~sda_i;
	assign stop = state_q.scl & scl_i & ~state_q.sda & sda_i;

	always_comb begin
		logic go_set;
		go_set = 1'b0;
		state_d = state_q;
		state_d.scl = scl_i;
		state_d.sda = sda_i;
		// rails off while enabled and the comparator has tripped
		state_d.pf_off = state_q.pf_en & ~powerfail_out_n_i;
		if (start) begin
			// also serves as repeated start
			state_d.st = I2C_ADDR;
			state_d.bits = 4'h0;
			state_d.oe = 1'b0;
		end else if (stop) begin
			state_d.st = I2C_IDLE;
			state_d.oe = 1'b0;
		end else if (rise) begin
			if (state_q.st inside {I2C_ADDR, I2C_REG, I2C_WDATA}) begin
				state_d.sh = {state_q.sh[6:0], sda_i};
				state_d.bits = next_bit(state_q.bits);
			end else if (state_q.st == I2C_RACK) begin
				state_d.nack = sda_i;
			end
		end else if (fall) begin
			unique case (state_q.st)
				I2C_IDLE: begin
					state_d.oe = 1'b0;
				end
				I2C_ADDR: begin
					if (state_q.bits == 4'h8) begin
						if (state_q.sh[7:1] == DEV_ADDR) begin
							state_d.rw = state_q.sh[0];
							state_d.oe = 1'b1;
							state_d.st = I2C_AACK;
						end else begin
							state_d.st = I2C_IDLE;
						end
					end
				end
				I2C_AACK: begin
					state_d.bits = 4'h0;
					if (state_q.rw) begin
						state_d = load_read(state_d, rd_w);
					end else begin
						state_d.oe = 1'b0;
						state_d.st = I2C_REG;
					end
				end
				I2C_REG: begin
					if (state_q.bits == 4'h8) begin
						state_d.ptr = state_q.sh;
						state_d.oe = 1'b1;
						state_d.st = I2C_WACK;
					end
				end
				I2C_WDATA: begin
					if (state_q.bits == 4'h8) begin
						state_d.oe = 1'b1;
						state_d.st = I2C_WACK;
						state_d.ptr = next_ptr(state_q.ptr);
						if (state_q.ptr == REG_MASK_OFS) begin
							state_d.mask = state_q.sh[MASK_WIDTH-1:0];
						end else if (state_q.ptr == REG_CTRL_OFS) begin
							state_d.pf_en = state_q.sh[CTRL_PF_BIT];
							// writing 0 leaves a pending acquisition alone
							go_set = state_q.sh[CTRL_CC_BIT];
						end
					end
				end
				I2C_WACK: begin
					state_d.oe = 1'b0;
					state_d.bits = 4'h0;
					state_d.st = I2C_WDATA;
				end
				I2C_RDATA: begin
					if (state_q.bits == 4'h7) begin
						state_d.oe = 1'b0;
						state_d.st = I2C_RACK;
					end else begin
						state_d.sh = {state_q.sh[6:0], 1'b0};
						state_d.oe = ~state_q.sh[6];
						state_d.bits = next_bit(state_q.bits);
					end
				end
				I2C_RACK: begin
					state_d.bits = 4'h0;
					if (state_q.nack) begin
						state_d.oe = 1'b0;
						state_d.st = I2C_IDLE;
					end else begin
						state_d = load_read(state_d, rd_w);
					end
				end
			endcase
		end
		// a new write of 1 wins over the automatic clear
		state_d.cc_go = go_set | (state_q.cc_go & ~cc_done_w);
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			state_q <= '{
				st: I2C_IDLE,
				scl: 1'b1,
				sda: 1'b1,
				bits: 4'h0,
				sh: 8'h00,
				rw: 1'b0,
				nack: 1'b0,
				ptr: 8'h00,
				oe: 1'b0,
				mask: MASK_RESET,
				pf_en: CTRL_PF_RESET,
				cc_go: CTRL_CC_RESET,
				pf_off: 1'b0
			};
		end else if (ce_i) begin
			state_q <= state_d;
		end
	end

	// events are the live switch conditions; masks never touch them
	assign event_w[MASK_FAULT_LSB +: 3] = sw_fault_i;
	assign event_w[MASK_ILIM_LSB +: 3] = sw_ilimit_i;

	pimsc_irq_gate #(
		.N(MASK_WIDTH)
	) u_irq_gate (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.event_i(event_w),
		.mask_i(state_q.mask),
		.irq_n_o(irq_out_n_o)
	);

	pimsc_coin_acq #(
		.CYCLES(ACQ_CYCLES)
	) u_coin_acq (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.go_i(state_q.cc_go),
		.compare_i(coin_cell_compare_i),
		.busy_o(cc_busy_w),
		.done_o(cc_done_w),
		.level_o(cc_level_w)
	);

	// open-drain data line only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe_o = state_q.oe;
	assign powerfail_shutdown_o = state_q.pf_off;
	assign coin_cell_measure_o = cc_busy_w;

endmodule : pimsc_top

// *** sim/pimsc_top_checker.sv ***
// port assertions of the i2c register bank
`timescale 1ns/10ps
module pimsc_top_checker #(
	parameter int ACQ_CYCLES = 100
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic scl_i,
	input wire logic [2:0] sw_fault_i,
	input wire logic [2:0] sw_ilimit_i,
	input wire logic powerfail_out_n_i,
	input wire logic irq_out_n_o,
	input wire logic powerfail_shutdown_o,
	input wire logic coin_cell_measure_o
);
	logic quiet_q;
	int hi_q;
	// quiet: bus untouched since reset, registers still at reset value
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			quiet_q <= 1'b1;
			hi_q <= 0;
		end else begin
			quiet_q <= quiet_q && scl_i;
			hi_q <= coin_cell_measure_o ? hi_q + 1 : 0;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	a_irq_idle_high: assert property (
		ce_i && !(|{sw_fault_i, sw_ilimit_i}) |=> irq_out_n_o)
		else $error("irq low without event");
	a_irq_reset_unmasked: assert property (
		ce_i && quiet_q && scl_i && (|{sw_fault_i, sw_ilimit_i})
		|=> !irq_out_n_o)
		else $error("event ignored with reset mask");
	a_irq_hold: assert property (
		ce_i && $past(ce_i) && $past(reset_n_i) && scl_i && $past(scl_i)
		&& $stable(sw_fault_i) && $stable(sw_ilimit_i)
		|=> $stable(irq_out_n_o))
		else $error("irq moved without cause");
	a_pf_idle_off: assert property (
		ce_i && powerfail_out_n_i |=> !powerfail_shutdown_o)
		else $error("shutdown without power fail");
	a_pf_hold_on: assert property (
		ce_i && $past(reset_n_i) && scl_i && $past(scl_i)
		&& !powerfail_out_n_i && powerfail_shutdown_o
		|=> powerfail_shutdown_o)
		else $error("shutdown dropped during fail");
	a_pf_reset_off: assert property (
		ce_i && quiet_q && scl_i |=> !powerfail_shutdown_o)
		else $error("shutdown with reset control");
	a_meas_reset_off: assert property (
		ce_i && quiet_q && scl_i |=> !coin_cell_measure_o)
		else $error("acquisition without trigger");
	a_meas_min_len: assert property (
		$past(reset_n_i) && $fell(coin_cell_measure_o)
		|-> hi_q == ACQ_CYCLES)
		else $error("acquisition length wrong");
endmodule : pimsc_top_checker

bind pimsc_top pimsc_top_checker #(.ACQ_CYCLES(ACQ_CYCLES)) chk_u (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .scl_i(scl_i),
	.sw_fault_i(sw_fault_i), .sw_ilimit_i(sw_ilimit_i),
	.powerfail_out_n_i(powerfail_out_n_i), .irq_out_n_o(irq_out_n_o),
	.powerfail_shutdown_o(powerfail_shutdown_o),
	.coin_cell_measure_o(coin_cell_measure_o));

// *** sim/pimsc_host.sv ***
// i2c host model driving the register bank
`timescale 1ns/10ps
module pimsc_host (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask : tick
	// data set mid low phase, sampled mid high phase
	task automatic bit_x(input logic b, output logic r);
		sda_low_o = !b;
		tick(2);
		scl_o = 1'b1;
		tick(2);
		r = sda_i;
		tick(2);
		scl_o = 1'b0;
		tick(2);
	endtask : bit_x
	task automatic byte_x(input logic [8:0] v, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) bit_x(v[i], r[i]);
	endtask : byte_x
	task automatic start_x();
		sda_low_o = 1'b0;
		tick(2);
		scl_o = 1'b1;
		tick(4);
		sda_low_o = 1'b1;
		tick(4);
		scl_o = 1'b0;
		tick(2);
	endtask : start_x
	task automatic stop_x();
		sda_low_o = 1'b1;
		tick(2);
		scl_o = 1'b1;
		tick(4);
		sda_low_o = 1'b0;
		tick(4);
	endtask : stop_x
	// one pointer write then a data write or a repeated-start read
	task automatic xfer(input logic [6:0] a, input logic [7:0] p,
		input logic rd, input logic [7:0] wd, output logic [7:0] rdat,
		output logic ack);
		logic [8:0] r0;
		logic [8:0] r1;
		logic [8:0] r2;
		start_x();
		byte_x({a, 2'b01}, r0);
		byte_x({p, 1'b1}, r1);
		if (rd) begin
			start_x();
			byte_x({a, 2'b11}, r2);
			ack = !r0[0] && !r1[0] && !r2[0];
			byte_x(9'h1FF, r2);
		end else begin
			byte_x({wd, 1'b1}, r2);
			ack = !r0[0] && !r1[0] && !r2[0];
		end
		rdat = r2[8:1];
		stop_x();
	endtask : xfer
endmodule : pimsc_host

// *** sim/pimsc_irq_mask_status_ctrl_bench.sv ***
// self-checking bench of the i2c register bank
`timescale 1ns/10ps
module pimsc_irq_mask_status_ctrl_bench;
	import pimsc_pkg::*;
	localparam int ACQ = 4;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic scl, sda_low, sda_oe, sda_o, sda;
	logic [2:0] fault = 3'h0;
	logic [2:0] ilim = 3'h0;
	logic seal = 1'b0;
	logic nvm = 1'b0;
	logic supply_n = 1'b1;
	logic button_n = 1'b1;
	logic [1:0] pstate = 2'h0;
	logic [1:0] cmp = 2'h0;
	logic pfail_n = 1'b1;
	logic ce = 1'b1;
	logic irq_n, pf_off, measure;
	logic [7:0] meas_cnt = 8'h00;
	int num_errors = 0;
	int n_checks = 0;
	// open-drain line with pull-up
	assign sda = (sda_oe ? sda_o : 1'b1) && !sda_low;
	always #10 clk_i = !clk_i;
	always @(posedge clk_i) if (measure === 1'b1) meas_cnt <= meas_cnt + 8'h01;
	pimsc_top #(.ACQ_CYCLES(ACQ)) dut_u (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .ce_i(ce), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_o(sda_oe), .sw_fault_i(fault),
		.sw_ilimit_i(ilim), .seal_broken_i(seal), .nvm_modified_i(nvm),
		.external_supply_detect_n_i(supply_n),
		.push_button_input_n_i(button_n), .power_state_i(pstate),
		.coin_cell_compare_i(cmp), .powerfail_out_n_i(pfail_n),
		.irq_out_n_o(irq_n), .powerfail_shutdown_o(pf_off),
		.coin_cell_measure_o(measure));
	pimsc_host host_u (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
		.sda_low_o(sda_low));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic [7:0] x;
		logic ack;
		host_u.xfer(DEV_ADDR_DEFAULT, p, 1'b0, d, x, ack);
		chk({7'h0, ack}, 8'h01);
	endtask : wr
	task automatic rd(input logic [7:0] p, input logic [7:0] exp);
		logic [7:0] x;
		logic ack;
		host_u.xfer(DEV_ADDR_DEFAULT, p, 1'b1, 8'h00, x, ack);
		chk({7'h0, ack}, 8'h01);
		chk(x, exp);
	endtask : rd
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (60000) @(posedge clk_i);
		num_errors++;
		end_of_test();
	end
	initial begin
		logic [7:0] x;
		logic ack;
		logic [7:0] base;
		repeat (6) @(negedge clk_i);
		reset_n_i = 1'b1;
		ilim = 3'h4;
		repeat (3) @(negedge clk_i);
		chk({7'h0, irq_n}, 8'h00);
		// clock enable low freezes the irq register
		ce = 1'b0;
		ilim = 3'h0;
		repeat (3) @(negedge clk_i);
		chk({7'h0, irq_n}, 8'h00);
		ce = 1'b1;
		repeat (2) @(negedge clk_i);
		chk({7'h0, irq_n}, 8'h01);
		rd(REG_MASK_OFS, 8'h00);
		rd(REG_CTRL_OFS, 8'h00);
		rd(8'h07, 8'h00);
		wr(REG_MASK_OFS, 8'hFF);
		rd(REG_MASK_OFS, 8'h3F);
		// each event masked alone, then the only unmasked one
		for (int i = 0; i < 6; i++) begin
			wr(REG_MASK_OFS, 8'h01 << i);
			{fault, ilim} = 6'h01 << i;
			repeat (3) @(negedge clk_i);
			chk({7'h0, irq_n}, 8'h01);
			wr(REG_MASK_OFS, 8'h3F ^ (8'h01 << i));
			{fault, ilim} = 6'h3F ^ (6'h01 << i);
			repeat (3) @(negedge clk_i);
			chk({7'h0, irq_n}, 8'h01);
			{fault, ilim} = 6'h01 << i;
			repeat (3) @(negedge clk_i);
			chk({7'h0, irq_n}, 8'h00);
			{fault, ilim} = 6'h00;
		end
		wr(REG_CTRL_OFS, 8'h02);
		rd(REG_CTRL_OFS, 8'h02);
		pfail_n = 1'b0;
		repeat (2) @(negedge clk_i);
		chk({7'h0, pf_off}, 8'h01);
		wr(REG_CTRL_OFS, 8'h00);
		chk({7'h0, pf_off}, 8'h00);
		chk(meas_cnt, 8'h00);
		pfail_n = 1'b1;
		for (int k = 0; k < 4; k++) begin
			pstate = 2'(k);
			cmp = 2'(3 - k);
			{seal, nvm, supply_n, button_n} = k[0] ? 4'hA : 4'h5;
			base = meas_cnt;
			wr(REG_CTRL_OFS, 8'h01);
			repeat (ACQ + 4) @(negedge clk_i);
			chk(meas_cnt - base, 8'(ACQ));
			rd(REG_CTRL_OFS, 8'h00);
			wr(REG_STATUS_OFS, 8'hFF);
			rd(REG_STATUS_OFS, {k[0], !k[0], !k[0], k[0], 2'(k),
				2'(3 - k)});
		end
		reset_n_i = 1'b0;
		repeat (2) @(negedge clk_i);
		reset_n_i = 1'b1;
		rd(REG_MASK_OFS, 8'h00);
		host_u.xfer(DEV_ADDR_DEFAULT ^ 7'h01, REG_MASK_OFS, 1'b0, 8'h15,
			x, ack);
		chk({7'h0, ack}, 8'h00);
		rd(REG_MASK_OFS, 8'h00);
		end_of_test();
	end
endmodule : pimsc_irq_mask_status_ctrl_bench
